// file: rtl/tcdma_pkg.sv
/*
  Shared constants for the two-channel DMA controller: register
  indices, control-word field positions, reset values, pacing codes,
  sequencer states and bus timing counts.
  Assumes a single 100 MHz core clock and APB register access.
*/
package tcdma_pkg;

  localparam int NCH = 2;
  localparam int NREG = 6;
  localparam int SYNC_STAGES = 2;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int APB_AW = 12;
  localparam int CLK_MHZ = 100;

  ////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_CH0_SRC_LO = 8'hC0;
  localparam logic [7:0] IDX_CH0_SRC_HI = 8'hC2;
  localparam logic [7:0] IDX_CH0_DST_LO = 8'hC4;
  localparam logic [7:0] IDX_CH0_DST_HI = 8'hC6;
  localparam logic [7:0] IDX_CH0_COUNT = 8'hC8;
  localparam logic [7:0] IDX_CH0_CTRL = 8'hCA;
  localparam logic [7:0] IDX_CH1_SRC_LO = 8'hD0;
  localparam logic [7:0] IDX_CH1_SRC_HI = 8'hD2;
  localparam logic [7:0] IDX_CH1_DST_LO = 8'hD4;
  localparam logic [7:0] IDX_CH1_DST_HI = 8'hD6;
  localparam logic [7:0] IDX_CH1_COUNT = 8'hD8;
  localparam logic [7:0] IDX_CH1_CTRL = 8'hDA;

  localparam logic [2:0] R_SRC_LO = 3'h0;
  localparam logic [2:0] R_SRC_HI = 3'h1;
  localparam logic [2:0] R_DST_LO = 3'h2;
  localparam logic [2:0] R_DST_HI = 3'h3;
  localparam logic [2:0] R_COUNT = 3'h4;
  localparam logic [2:0] R_CTRL = 3'h5;

  localparam logic [7:0] REG_IDX [NCH][NREG] = '{
    '{IDX_CH0_SRC_LO, IDX_CH0_SRC_HI, IDX_CH0_DST_LO,
      IDX_CH0_DST_HI, IDX_CH0_COUNT, IDX_CH0_CTRL},
    '{IDX_CH1_SRC_LO, IDX_CH1_SRC_HI, IDX_CH1_DST_LO,
      IDX_CH1_DST_HI, IDX_CH1_COUNT, IDX_CH1_CTRL}};

  ////////////////////////////////////////////////////////////////////
  // Control word fields
  localparam int CW_DST_MEM = 15;
  localparam int CW_DST_DEC = 14;
  localparam int CW_DST_INC = 13;
  localparam int CW_SRC_MEM = 12;
  localparam int CW_SRC_DEC = 11;
  localparam int CW_SRC_INC = 10;
  localparam int CW_TOC = 9;
  localparam int CW_INT = 8;
  localparam int CW_SYN_HI = 7;
  localparam int CW_SYN_LO = 6;
  localparam int CW_PRIO = 5;
  localparam int CW_TREQ = 4;
  localparam int CW_PERMIT = 2;
  localparam int CW_RUN = 1;

  localparam logic [1:0] PACE_FREE = 2'h0;
  localparam logic [1:0] PACE_SRC = 2'h1;
  localparam logic [1:0] PACE_DST = 2'h2;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  ////////////////////////////////////////////////////////////////////
  // Timing in core clocks
  localparam int BUS_CYC_MIN_CLK = 4;
  localparam int DST_GAP_CLK = 2;
  localparam logic [1:0] CYC_LAST = 2'(BUS_CYC_MIN_CLK - 1);
  localparam logic [1:0] GAP_LAST = 2'(DST_GAP_CLK + SYNC_STAGES - 1);
  localparam logic [3:0] XFER_LAST = 4'(2 * BUS_CYC_MIN_CLK - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_STORE = 2'h3,
    ST_GAP = 2'h2
  } tcdma_state_t;

endpackage

// file: rtl/tcdma_sync.sv
/*
  Two-flop level synchroniser, one per bit.
  Assumes inputs are slow levels from pins outside the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tcdma_sync
  import tcdma_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule
`default_nettype wire

// file: rtl/tcdma_top.sv
/*
  Two-channel DMA controller: APB register file, channel arbiter and
  fetch-then-store sequencer driving an 8-bit system bus.
  Assumes the system bus answers with bus_ready_i on core_clk_i, the
  request pins and the halt pin are asynchronous, and an outside
  interrupt controller takes the done pulses.
*/
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcdma_top
  import tcdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NCH-1:0] transfer_request_input_i,
  input wire logic timer_request_i,
  input wire logic nmi_i,
  output logic bus_req_o,
  output logic bus_wr_o,
  output logic bus_mem_o,
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic [DATA_W-1:0] bus_wdata_o,
  input wire logic [DATA_W-1:0] bus_rdata_i,
  input wire logic bus_ready_i,
  output logic [NCH-1:0] done_irq_o
);

  tcdma_state_t st_r, st_nxt;
  logic act_r;
  logic [1:0] cyc_r;
  logic [DATA_W-1:0] data_r;
  logic [31:0] prdata_r;
  logic [NCH-1:0] drq_s;
  logic nmi_s;
  logic [NCH-1:0] req;
  logic [15:0] ctl [NCH];
  logic [15:0] regv [NCH][NREG];
  logic [ADDR_W-1:0] sptr [NCH];
  logic [ADDR_W-1:0] dptr [NCH];
  logic hit, hit_ch, sw_wr, grant_ch, start, prio_eq;
  logic [2:0] hit_reg;
  logic phase_end, xfer_done;

  function automatic logic [ADDR_W-1:0] step_ptr(
    input logic [ADDR_W-1:0] p, input logic inc, input logic dec);
    // Both or neither bit set holds the pointer
    return (inc == dec) ? p : (inc ? p + 20'h00001 : p - 20'h00001);
  endfunction

  function automatic logic pace_dst(input logic [15:0] w);
    return w[CW_SYN_HI:CW_SYN_LO] == PACE_DST;
  endfunction
  function automatic logic pace_free(input logic [15:0] w);
    return w[CW_SYN_HI:CW_SYN_LO] != PACE_SRC && !pace_dst(w);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  tcdma_sync #(.W(NCH + 1)) tcdma_sync_inst (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .d_i({nmi_i, transfer_request_input_i}),
    .q_o({nmi_s, drq_s})
  );

  ////////////////////////////////////////////////////////////////////
  // APB decode, zero wait states
  always_comb begin
    hit = 1'b0;
    hit_ch = 1'b0;
    hit_reg = R_SRC_LO;
    for (int c = 0; c < NCH; c++) begin
      for (int r = 0; r < NREG; r++) begin
        if (paddr_i == {2'b00, REG_IDX[c][r], 2'b00}) begin
          hit = 1'b1;
          hit_ch = 1'(c);
          hit_reg = 3'(r);
        end
      end
    end
  end

  assign sw_wr = psel_i && penable_i && pwrite_i && hit;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign prdata_o = prdata_r;

  // Captured in setup so read data comes from a flop
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_r <= 32'h00000000;
    end else if (psel_i && !penable_i) begin
      prdata_r <= hit ? {16'h0000, regv[hit_ch][hit_reg]} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [15:0] sl_r, sh_r, dl_r, dh_r, cnt_r, ctl_r;
    logic irq_r;
    logic [ADDR_W-1:0] s_nxt, d_nxt;
    logic wr_c, done_c, term_c;

    assign wr_c = sw_wr && (hit_ch == 1'(c));
    assign done_c = xfer_done && (act_r == 1'(c));
    assign sptr[c] = {sh_r[3:0], sl_r};
    assign dptr[c] = {dh_r[3:0], dl_r};
    assign s_nxt = step_ptr(sptr[c], ctl_r[CW_SRC_INC], ctl_r[CW_SRC_DEC]);
    assign d_nxt = step_ptr(dptr[c], ctl_r[CW_DST_INC], ctl_r[CW_DST_DEC]);
    // Count of zero wraps to all ones, giving 64K transfers
    assign term_c = done_c && (cnt_r == CNT_ONE) &&
                    (ctl_r[CW_TOC] || pace_free(ctl_r));
    // Terminating transfer must not chain another one
    assign req[c] = ctl_r[CW_RUN] && !nmi_s && !term_c &&
                    (pace_free(ctl_r) || drq_s[c] ||
                     (ctl_r[CW_TREQ] && timer_request_i));
    assign ctl[c] = ctl_r;
    assign done_irq_o[c] = irq_r;
    assign regv[c] = '{sl_r, sh_r, dl_r, dh_r, cnt_r, ctl_r};

    // Software write wins over a step in the same cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sl_r <= PTR_RST;
        sh_r <= PTR_RST;
        dl_r <= PTR_RST;
        dh_r <= PTR_RST;
      end else begin
        if (done_c) begin
          sl_r <= s_nxt[15:0];
          sh_r <= {sh_r[15:4], s_nxt[19:16]};
          dl_r <= d_nxt[15:0];
          dh_r <= {dh_r[15:4], d_nxt[19:16]};
        end
        if (wr_c && hit_reg == R_SRC_LO) begin
          sl_r <= pwdata_i[15:0];
        end
        if (wr_c && hit_reg == R_SRC_HI) begin
          sh_r <= pwdata_i[15:0];
        end
        if (wr_c && hit_reg == R_DST_LO) begin
          dl_r <= pwdata_i[15:0];
        end
        if (wr_c && hit_reg == R_DST_HI) begin
          dh_r <= pwdata_i[15:0];
        end
      end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_r <= CNT_RST;
      end else if (wr_c && hit_reg == R_COUNT) begin
        cnt_r <= pwdata_i[15:0];
      end else if (done_c) begin
        cnt_r <= cnt_r - CNT_ONE;
      end
    end

    // Permit bit is never stored, so it reads as zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ctl_r <= CTRL_RST;
      end else begin
        if (term_c) begin
          ctl_r[CW_RUN] <= 1'b0;
        end
        if (wr_c && hit_reg == R_CTRL) begin
          ctl_r[15:CW_TREQ] <= pwdata_i[15:CW_TREQ];
          if (pwdata_i[CW_PERMIT]) begin
            ctl_r[CW_RUN] <= pwdata_i[CW_RUN];
          end
        end
      end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        irq_r <= 1'b0;
      end else begin
        irq_r <= term_c && ctl_r[CW_INT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Arbitration
  assign prio_eq = ctl[0][CW_PRIO] == ctl[1][CW_PRIO];

  always_comb begin
    grant_ch = req[1];
    if (&req) begin
      grant_ch = prio_eq ? !act_r : ctl[1][CW_PRIO];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  assign phase_end = (st_r == ST_FETCH || st_r == ST_STORE) &&
                     cyc_r == CYC_LAST && bus_ready_i;
  assign xfer_done = st_r == ST_STORE && phase_end;

  always_comb begin
    st_nxt = st_r;
    start = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (|req) begin
          st_nxt = ST_FETCH;
          start = 1'b1;
        end
      end
      ST_FETCH: begin
        // A stop written during the fetch drops the store
        if (phase_end) begin
          st_nxt = ctl[act_r][CW_RUN] ? ST_STORE : ST_IDLE;
        end
      end
      ST_STORE: begin
        if (phase_end && pace_dst(ctl[act_r])) begin
          st_nxt = ST_GAP;
        end else if (phase_end && |req) begin
          st_nxt = ST_FETCH;
          start = 1'b1;
        end else if (phase_end) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_GAP: begin
        // Gap covers the synchroniser delay on the request pin
        if (cyc_r == GAP_LAST && |req) begin
          st_nxt = ST_FETCH;
          start = 1'b1;
        end else if (cyc_r == GAP_LAST) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_r <= 1'b0;
    end else if (start) begin
      act_r <= grant_ch;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_r <= 2'h0;
    end else if (st_nxt != st_r || start) begin
      cyc_r <= 2'h0;
    end else if (cyc_r != CYC_LAST) begin
      cyc_r <= cyc_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_r <= '0;
    end else if (st_r == ST_FETCH && phase_end) begin
      data_r <= bus_rdata_i;
    end
  end

  // Address follows live pointers so writes act on the current cycle
  assign bus_req_o = st_r == ST_FETCH || st_r == ST_STORE;
  assign bus_wr_o = st_r == ST_STORE;
  assign bus_addr_o = bus_wr_o ? dptr[act_r] : sptr[act_r];
  assign bus_mem_o = bus_wr_o ? ctl[act_r][CW_DST_MEM] : ctl[act_r][CW_SRC_MEM];
  assign bus_wdata_o = data_r;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [3:0] xlen_r;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xlen_r <= 4'h0;
    end else if (start) begin
      xlen_r <= 4'h0;
    end else if (bus_req_o && xlen_r != 4'hF) begin
      xlen_r <= xlen_r + 4'h1;
    end
  end

  xfer_len_a: assert property (xfer_done |-> xlen_r >= XFER_LAST)
    else $error("transfer shorter than minimum");
  // Request of the channel just granted, not of the one before
  dst_wait_a: assert property (
    (st_r == ST_FETCH && $past(st_r) != ST_FETCH && pace_dst(ctl[act_r])
     && !ctl[act_r][CW_TREQ]) |-> (act_r ? $past(drq_s[1]) : $past(drq_s[0])))
    else $error("destination fetch without request");
  dst_gap_a: assert property (
    (xfer_done && pace_dst(ctl[act_r])) |=> !bus_req_o [*4])
    else $error("bus not released after paced store");
  cnt_dec_a: assert property (
    (xfer_done && !act_r && !sw_wr) |=> g_ch[0].cnt_r == $past(g_ch[0].cnt_r) - CNT_ONE)
    else $error("count not decremented");
  // The other channel may take the bus at once
  tc_stop_a: assert property (
    (xfer_done && g_ch[0].term_c && !sw_wr) |=>
    !ctl[0][CW_RUN] ##1 !(st_r == ST_FETCH && !act_r))
    else $error("channel ran past terminal count");
  run_keep_a: assert property (
    (sw_wr && hit_reg == R_CTRL && !pwdata_i[CW_PERMIT] && !xfer_done)
    |=> ctl[$past(hit_ch)][CW_RUN] == $past(ctl[hit_ch][CW_RUN]) && !ctl[$past(hit_ch)][CW_PERMIT])
    else $error("run bit changed without permit");
  src_step_a: assert property (
    (xfer_done && !act_r && !sw_wr && ctl[0][CW_SRC_INC] && !ctl[0][CW_SRC_DEC])
    |=> sptr[0] == $past(sptr[0]) + 20'h00001)
    else $error("source pointer not incremented");
  alt_a: assert property (
    (start && &req && prio_eq) |=> act_r != $past(act_r))
    else $error("equal priority did not alternate");
  halt_a: assert property ((nmi_s && st_r == ST_IDLE) |=> st_r == ST_IDLE)
    else $error("transfer started during halt");

  cov_dst_c: cover property (xfer_done && pace_dst(ctl[act_r]));
  cov_b2b_c: cover property (xfer_done ##1 st_r == ST_FETCH);
  cov_term_c: cover property (g_ch[1].term_c);
  cov_alt_c: cover property (start && &req && prio_eq);

endmodule
`default_nettype wire

// file: tb/tcdma_bus_model.sv
/*
  Bus partner model: memory and I/O spaces behind the system bus.
  Assumes one fetch or store at a time, ended by ready in its 4th+ clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tcdma_bus_model
  import tcdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] waits_i,
  input wire logic bus_req_i,
  input wire logic bus_wr_i,
  input wire logic bus_mem_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [DATA_W-1:0] bus_wdata_i,
  output logic [DATA_W-1:0] bus_rdata_o,
  output logic bus_ready_o
);
  logic [3:0] cnt_r;
  logic [7:0] junk_r;
  int cyc_r = 0;
  // Store log: space and address, datum, cycle stamp
  logic [ADDR_W:0] st_a [$];
  logic [DATA_W-1:0] st_d [$];
  int st_t [$];

  ////////////////////////////////////////////////////////////////
  // Ready only from clock 4 + waits of the cycle, after 3 + waits clocks
  assign bus_ready_o = bus_req_i && (cnt_r >= 4'h3 + waits_i);
  // Junk outside a ready fetch, so a late sample never passes
  assign bus_rdata_o = (bus_req_i && !bus_wr_i && bus_ready_o) ?
    (bus_addr_i[7:0] ^ (bus_mem_i ? 8'h5A : 8'hC3)) : junk_r;

  always @(posedge core_clk_i) begin
    cyc_r <= cyc_r + 1;
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 4'h0;
      junk_r <= 8'h00;
    end else begin
      junk_r <= junk_r + 8'h3B;
      cnt_r <= (!bus_req_i || bus_ready_o) ? 4'h0 : cnt_r + 4'h1;
      if (bus_req_i && bus_wr_i && bus_ready_o) begin
        st_a.push_back({bus_mem_i, bus_addr_i});
        st_d.push_back(bus_wdata_i);
        st_t.push_back(cyc_r);
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tcdma_top_tb.sv
/*
  Self-checking bench for the two-channel DMA controller.
  Assumes zero-wait APB and the bus partner in tcdma_bus_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tcdma_top_tb
  import tcdma_pkg::*;
;
  localparam logic [15:0] GO = 16'h0006, TOC = 16'h0200, IEN = 16'h0100, SMEM = 16'h1000;
  localparam logic [15:0] SINC = 16'h0400, SDEC = 16'h0800, DMEM = 16'h8000, DINC = 16'h2000;
  localparam logic [15:0] DDEC = 16'h4000, PSRC = 16'h0040, PDST = 16'h0080, PRI = 16'h0020;
  localparam logic [15:0] TRQ = 16'h0010;
  logic clk, arst_n, psel, penable, pwrite, timer_req, nmi, pready, pslverr, er;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NCH-1:0] dreq, done_irq;
  logic bus_req, bus_wr, bus_mem, bus_ready;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  logic [3:0] waits, q;
  int err_total = 0, compares = 0, b;
  int done_n [NCH] = '{0, 0};

  tcdma_top tcdma_top_inst (.core_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .transfer_request_input_i(dreq), .timer_request_i(timer_req), .nmi_i(nmi),
    .bus_req_o(bus_req), .bus_wr_o(bus_wr), .bus_mem_o(bus_mem), .bus_addr_o(bus_addr),
    .bus_wdata_o(bus_wdata), .bus_rdata_i(bus_rdata), .bus_ready_i(bus_ready),
    .done_irq_o(done_irq));
  tcdma_bus_model tcdma_bus_model_inst (.core_clk_i(clk), .arst_n_i(arst_n),
    .waits_i(waits), .bus_req_i(bus_req), .bus_wr_i(bus_wr), .bus_mem_i(bus_mem),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata),
    .bus_ready_o(bus_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (arst_n === 1'b1 && done_irq[c] === 1'b1) done_n[c]++;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Upper data half driven high: the block must ignore it
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'hFFFF, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [APB_AW-1:0] ra(input int c, input logic [2:0] r);
    return {2'b00, REG_IDX[c][r], 2'b00};
  endfunction

  task automatic rchk(input int c, input logic [2:0] r, input logic [31:0] e, input string nm);
    apb(1'b0, ra(c, r), 16'h0000);
    chk(nm, e, rd);
  endtask

  task automatic prog(input int c, input logic [31:0] s, d, input logic [15:0] n, w);
    apb(1'b1, ra(c, R_SRC_LO), s[15:0]);
    apb(1'b1, ra(c, R_SRC_HI), s[31:16]);
    apb(1'b1, ra(c, R_DST_LO), d[15:0]);
    apb(1'b1, ra(c, R_DST_HI), d[31:16]);
    apb(1'b1, ra(c, R_COUNT), n);
    apb(1'b1, ra(c, R_CTRL), w);
  endtask

  function automatic int sz();
    return tcdma_bus_model_inst.st_a.size();
  endfunction

  function automatic int gap(input int k);
    return tcdma_bus_model_inst.st_t[k] - tcdma_bus_model_inst.st_t[k-1];
  endfunction

  // Bounded wait for the store log to reach n entries
  task automatic wait_st(input int n, input int lim);
    int k;
    k = 0;
    while (sz() < n && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk("store count", n, sz());
  endtask

  task automatic chk_st(input int k, input logic [20:0] a, input logic [19:0] sa, input logic sm);
    chk("store addr", a, tcdma_bus_model_inst.st_a[k]);
    chk("store data", sa[7:0] ^ (sm ? 8'h5A : 8'hC3), tcdma_bus_model_inst.st_d[k]);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    dreq = '0;
    timer_req = 1'b0;
    nmi = 1'b0;
    waits = 4'h0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rchk(0, R_CTRL, 32'h0, "ctrl rst");
    apb(1'b1, 12'h3FC, 16'h1234);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b0, 12'h3FC, 16'h0000);
    chk("unmapped rd", 32'h0, rd);
    // Destination pacing, pin held low first
    apb(1'b1, ra(1, R_CTRL), PDST | 16'h0002);
    rchk(1, R_CTRL, {16'h0, PDST}, "run no permit");
    b = sz();
    prog(1, 32'h0000_0040, 32'h0000_0080, 16'h0002, GO | PDST | TOC | SINC | DMEM);
    rchk(1, R_CTRL, {16'h0, PDST | TOC | SINC | DMEM | 16'h0002}, "run set");
    repeat (30) @(posedge clk);
    chk("dst idle", b, sz());
    dreq <= 2'b10;
    wait_st(b + 2, 200);
    dreq <= 2'b00;
    for (int i = 0; i < 2; i++) chk_st(b + i, {1'b1, 20'h00080}, 20'h00040 + 20'(i), 1'b0);
    chk("dst gap", 32'h1, {31'h0, gap(b + 1) >= 10});
    rchk(1, R_COUNT, 32'h0, "dst count");
    chk("dst stop", b + 2, sz());
    // Free pacing, memory to I/O, source wraps past the top
    b = sz();
    prog(0, 32'hABCF_FFFF, 32'h0001_2345, 16'h0003, GO | IEN | SMEM | SINC | DDEC);
    wait_st(b + 3, 200);
    for (int i = 0; i < 3; i++) chk_st(b + i, {1'b0, 20'h12345 - 20'(i)}, 20'hFFFFF + 20'(i), 1'b1);
    chk("free gap", 32'd8, gap(b + 2));
    rchk(0, R_SRC_LO, 32'h0002, "src lo");
    rchk(0, R_SRC_HI, 32'hABC0, "src hi");
    rchk(0, R_DST_LO, 32'h2342, "dst lo");
    rchk(0, R_COUNT, 32'h0, "free count");
    rchk(0, R_CTRL, {16'h0, IEN | SMEM | SINC | DDEC}, "free stop");
    chk("done ch0", 32'h1, done_n[0]);
    chk("done ch1", 32'h0, done_n[1]);
    // Source pacing from the timer, slow bus, pointers held
    waits <= 4'h2;
    timer_req <= 1'b1;
    b = sz();
    prog(1, 32'h0000_0777, 32'h0003_0100, 16'h0002, GO | TOC | PSRC | SINC | SDEC | DMEM | DINC | DDEC);
    repeat (30) @(posedge clk);
    chk("timer off", b, sz());
    apb(1'b1, ra(1, R_CTRL), TOC | PSRC | SINC | SDEC | DMEM | DINC | DDEC | TRQ);
    wait_st(b + 2, 200);
    timer_req <= 1'b0;
    for (int i = 0; i < 2; i++) chk_st(b + i, {1'b1, 20'h30100}, 20'h00777, 1'b0);
    chk("wait gap", 32'd12, gap(b + 1));
    waits <= 4'h0;
    // Halt input blocks transfers
    nmi <= 1'b1;
    b = sz();
    prog(0, 32'h0000_0011, 32'h0000_0020, 16'h0001, GO | TOC | PSRC | PDST);
    repeat (20) @(posedge clk);
    chk("nmi hold", b, sz());
    nmi <= 1'b0;
    wait_st(b + 1, 100);
    chk_st(b, {1'b0, 20'h00020}, 20'h00011, 1'b0);
    // Both channels pending at halt release
    for (int p = 0; p < 2; p++) begin
      nmi <= 1'b1;
      b = sz();
      prog(0, 32'h0, 32'h0000_0100, 16'h0002, GO | DMEM);
      prog(1, 32'h0, 32'h0000_0200, 16'h0002, GO | DMEM | (p == 0 ? PRI : 16'h0000));
      nmi <= 1'b0;
      wait_st(b + 4, 300);
      for (int i = 0; i < 4; i++) q[3-i] = tcdma_bus_model_inst.st_a[b+i][9];
      if (p == 0) chk("prio order", 32'hC, {28'h0, q});
      if (p == 1) chk("alternate", 32'h1, {31'h0, q == 4'hA || q == 4'h5});
    end
    // Zero count runs on; live pointer write; reset mid-run
    b = sz();
    prog(0, 32'h0, 32'h0000_0300, 16'h0000, GO | TOC);
    wait_st(b + 3, 200);
    rchk(0, R_CTRL, {16'h0, TOC | 16'h0002}, "count wraps");
    apb(1'b1, ra(0, R_DST_LO), 16'h0305);
    b = sz();
    wait_st(b + 2, 100);
    chk("live dst", {11'h0, 1'b0, 20'h00305}, tcdma_bus_model_inst.st_a[b+1]);
    // Stop with permit: at most the store under way still lands
    apb(1'b1, ra(0, R_CTRL), TOC | 16'h0004);
    b = sz();
    repeat (20) @(posedge clk);
    chk("stopped", 32'h1, {31'h0, sz() - b <= 1});
    apb(1'b1, ra(0, R_CTRL), GO | TOC);
    repeat (4) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    chk("req in reset", 32'h0, {31'h0, bus_req});
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    b = sz();
    repeat (20) @(posedge clk);
    chk("idle after reset", b, sz());
    rchk(0, R_CTRL, 32'h0, "ctrl after reset");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("BAD watchdog exp finish got timeout");
    test_done();
  end
endmodule
`default_nettype wire
